// ===== aslpc_pkg.sv
// constants for the global chip control register bank: offset, field layout, reset values
// assumes a single clock domain shared with the config port and the message decoder
// Behaviour
// R1 - l1 enable bit set allows aspm l1 on upstream port; clear forbids it
// R2 - l1 enable bit drives l1 support report of every function
// R3 - fields clear on fundamental reset and load from eeprom image
// R4 - software keeps the diagnostic bit at zero
// R5 - eeprom image keeps the diagnostic bit at zero
// R6 - bits 27 to 22 read zero, writes ignored
// R7 - scale code 00/01/10/11 means 1.0/0.1/0.01/0.001
// R8 - minimum power is value field times scale multiplier
// R9 - nonzero value: compare minimum against each received slot limit
// R10 - zero value: skip comparison, no limit applies
// R11 - motherboard-down designs program the value field to zero
// R12 - action 00 ignore, 01 flag pin, 10 flag and unsupported, 11 reserved
// R13 - compare in common unit; hold result until next message or reset (code also clears it when the value field goes to zero)
`default_nettype none
package aslpc_pkg;
  localparam logic [7:0]  GCC_OFFSET     = 8'hb8;
  localparam int          L1_EN_BIT      = 29;
  localparam int          DIAG_BIT       = 28;
  localparam int          SCALE_LSB      = 20;
  localparam int          VALUE_LSB      = 12;
  localparam int          ACTION_LSB     = 10;
  localparam int          POWER_W        = 18;
  localparam logic        L1_EN_RST      = 1'h0;
  localparam logic        DIAG_RST       = 1'h0;
  localparam logic [1:0]  SCALE_RST      = 2'h0;
  localparam logic [7:0]  VALUE_RST      = 8'h00;
  localparam logic [1:0]  ACTION_RST     = 2'h0;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;
  localparam logic [17:0] FACTOR_X1      = 18'h003e8;
  localparam logic [17:0] FACTOR_X0P1    = 18'h00064;
  localparam logic [17:0] FACTOR_X0P01   = 18'h0000a;
  localparam logic [17:0] FACTOR_X0P001  = 18'h00001;

  typedef enum logic [1:0] {
    ACT_IGNORE = 2'b00,
    ACT_FLAG   = 2'b01,
    ACT_BLOCK  = 2'b10,
    ACT_RSVD   = 2'b11
  } aslpc_action_t;
endpackage
`default_nettype wire

// ===== aslpc_power_scale.sv
// scales an 8-bit power value by its 2-bit scale code into milliwatt units
// assumes the caller registers the result where timing needs it
`default_nettype none
module aslpc_power_scale
  import aslpc_pkg::*;
(
  input  wire logic [7:0]         value,
  input  wire logic [1:0]         scale,
  output logic      [POWER_W-1:0] milli
);
  logic [POWER_W-1:0] factor;
  logic [POWER_W-1:0] wide_value;

  always_comb
  begin
    case (scale) // see R7
      2'h0:    factor = FACTOR_X1;
      2'h1:    factor = FACTOR_X0P1;
      2'h2:    factor = FACTOR_X0P01;
      default: factor = FACTOR_X0P001;
    endcase
  end

  assign wide_value = {{(POWER_W-8){1'b0}}, value};
  // 255 x 1000 fits in 18 bits, so the cut loses nothing
  assign milli = POWER_W'(wide_value * factor); // see R8
endmodule
`default_nettype wire

// ===== aslpc_global_ctrl.sv
// global chip control bank: l1 enable, diagnostic bit, minimum slot power and excess action
// assumes config port, eeprom loader and message decoder all run on clock
`default_nettype none
module aslpc_global_ctrl
  import aslpc_pkg::*;
#(
  parameter int NUM_FUNCS = 1
)
(
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 cfg_wr_en,
  input  wire logic                 cfg_rd_en,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [3:0]           cfg_byte_en,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  input  wire logic                 eeprom_load_valid,
  input  wire logic [31:0]          eeprom_load_data,
  input  wire logic                 slot_limit_valid,
  input  wire logic [7:0]           slot_limit_value,
  input  wire logic [1:0]           slot_limit_scale,
  input  wire logic                 req_valid,
  input  wire logic                 req_is_cfg,
  input  wire logic                 req_is_slot_limit,
  output logic                      req_unsupported,
  output logic                      link_low_power_l1_enable,
  output logic      [NUM_FUNCS-1:0] aspm_support_l1,
  output logic      [1:0]           power_excess_action,
  output logic                      power_excess_out
);
  logic               l1_q, l1_d;
  logic               diag_q, diag_d;
  logic [1:0]         scale_q, scale_d;
  logic [7:0]         value_q, value_d;
  logic [1:0]         action_q, action_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               excess_q, excess_d;
  logic               pwr_out_q, pwr_out_d;
  logic               block_q, block_d;
  logic [31:0]        cur_word;
  logic [31:0]        merged;
  logic [31:0]        src;
  logic               wr_hit;
  logic [POWER_W-1:0] min_milli;
  logic [POWER_W-1:0] limit_milli;

  // reserved ranges are hard zeros, never stored
  assign cur_word = {2'h0, l1_q, diag_q, 6'h00, scale_q, value_q, action_q,
                     10'h000}; // see R6
  assign wr_hit   = cfg_wr_en && (cfg_addr == GCC_OFFSET);

  always_comb
  begin
    merged = cur_word;
    for (int i = 0; i < 4; i++)
    begin
      if (cfg_byte_en[i])
      begin
        merged[8*i +: 8] = cfg_wdata[8*i +: 8];
      end
    end
  end

  // eeprom load wins over a software write in the same cycle
  assign src = eeprom_load_valid ? eeprom_load_data : merged; // see R3

  always_comb
  begin
    l1_d     = l1_q;
    diag_d   = diag_q;
    scale_d  = scale_q;
    value_d  = value_q;
    action_d = action_q;
    if (eeprom_load_valid || wr_hit) // see R3
    begin
      l1_d     = src[L1_EN_BIT];
      diag_d   = src[DIAG_BIT];
      scale_d  = src[SCALE_LSB +: 2];
      value_d  = src[VALUE_LSB +: 8];
      action_d = src[ACTION_LSB +: 2];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n) // see R3
    begin
      l1_q     <= L1_EN_RST;
      diag_q   <= DIAG_RST;
      scale_q  <= SCALE_RST;
      value_q  <= VALUE_RST;
      action_q <= ACTION_RST;
    end
    else
    begin
      l1_q     <= l1_d;
      diag_q   <= diag_d;
      scale_q  <= scale_d;
      value_q  <= value_d;
      action_q <= action_d;
    end
  end

  // read data: unmapped offsets answer zero, data holds between reads
  always_comb
  begin
    rdata_d = rdata_q;
    if (cfg_rd_en)
    begin
      rdata_d = (cfg_addr == GCC_OFFSET) ? cur_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rdata_q <= RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // both figures go to milliwatts so a plain magnitude compare works
  aslpc_power_scale u_min_scale (
    .value (value_q),
    .scale (scale_q),
    .milli (min_milli)
  ); // see R13

  aslpc_power_scale u_limit_scale (
    .value (slot_limit_value),
    .scale (slot_limit_scale),
    .milli (limit_milli)
  ); // see R13

  always_comb
  begin
    excess_d = excess_q; // see R13
    if (slot_limit_valid)
    begin
      excess_d = (value_q != 8'h00) && (limit_milli < min_milli); // see R9
    end
    if (value_d == 8'h00)
    begin
      excess_d = 1'b0; // see R10
    end
    // reserved action code behaves as ignore
    pwr_out_d = excess_d && ((action_d == ACT_FLAG) || (action_d == ACT_BLOCK)); // see R12
    block_d   = excess_d && (action_d == ACT_BLOCK); // see R12
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      excess_q  <= 1'b0;
      pwr_out_q <= 1'b0;
      block_q   <= 1'b0;
    end
    else
    begin
      excess_q  <= excess_d;
      pwr_out_q <= pwr_out_d;
      block_q   <= block_d;
    end
  end

  assign cfg_rdata                = rdata_q;
  assign link_low_power_l1_enable = l1_q; // see R1
  assign aspm_support_l1          = {NUM_FUNCS{l1_q}}; // see R2
  assign power_excess_action      = action_q;
  assign power_excess_out         = pwr_out_q;
  // config requests and slot limit messages always pass so software can recover
  assign req_unsupported = req_valid && block_q && !req_is_cfg && !req_is_slot_limit; // see R12

  chk_l1_write: assert property (@(posedge clock) disable iff (!reset_n) // see R1
    (wr_hit && cfg_byte_en[3] && !eeprom_load_valid)
    |=> (link_low_power_l1_enable == $past(cfg_wdata[L1_EN_BIT])))
    else $error("l1 enable did not follow write");

  chk_support_all: assert property (@(posedge clock) disable iff (!reset_n) // see R2
    ##1 (aspm_support_l1 == {NUM_FUNCS{link_low_power_l1_enable}}))
    else $error("l1 support report differs from enable");

  chk_eeprom_load: assert property (@(posedge clock) disable iff (!reset_n) // see R3
    eeprom_load_valid |=> (link_low_power_l1_enable == $past(eeprom_load_data[L1_EN_BIT]))
      && (value_q == $past(eeprom_load_data[VALUE_LSB +: 8])))
    else $error("eeprom load not taken");

  chk_rsvd_zero: assert property (@(posedge clock) disable iff (!reset_n) // see R6
    cfg_rd_en |=> (cfg_rdata[27:22] == 6'h00))
    else $error("reserved bits read nonzero");

  chk_scale_milli: assert property (@(posedge clock) disable iff (!reset_n) // see R8
    (scale_q == 2'h1) |-> (min_milli == POWER_W'(value_q) * 18'h00064))
    else $error("minimum power scaling wrong");

  chk_compare_fail: assert property (@(posedge clock) disable iff (!reset_n) // see R9
    (slot_limit_valid && (value_q != 8'h00) && (limit_milli < min_milli)
      && !eeprom_load_valid && !wr_hit)
    |=> excess_q && (power_excess_out == (action_q inside {ACT_FLAG, ACT_BLOCK})))
    else $error("failed compare not flagged");

  chk_skip_zero: assert property (@(posedge clock) disable iff (!reset_n) // see R10
    (value_q == 8'h00) |-> (!excess_q && !power_excess_out && !req_unsupported))
    else $error("zero minimum still flagged");

  chk_hold_result: assert property (@(posedge clock) disable iff (!reset_n) // see R13
    (!slot_limit_valid && (value_d != 8'h00)) |=> $stable(excess_q))
    else $error("compare result changed without message");

  chk_block_req: assert property (@(posedge clock) disable iff (!reset_n) // see R12
    (excess_q && (action_q == ACT_BLOCK) && $stable(action_q) && $stable(excess_q)
      && req_valid && !req_is_cfg && !req_is_slot_limit)
    |-> req_unsupported)
    else $error("blocked request not refused");
endmodule
`default_nettype wire

// ===== aslpc_link_partner.sv
// upstream link partner: slot limit messages and request classes
// assumes the caller lives on the same clock; drives at falling edge
`default_nettype none
module aslpc_link_partner
(
  input  wire logic       clock,
  output logic            slot_limit_valid,
  output logic [7:0]      slot_limit_value,
  output logic [1:0]      slot_limit_scale,
  output logic            req_valid,
  output logic            req_is_cfg,
  output logic            req_is_slot_limit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {slot_limit_valid, slot_limit_value, slot_limit_scale} = 11'h000;
    {req_valid, req_is_cfg, req_is_slot_limit} = 3'h0;
  end
  task automatic send(input logic [7:0] v, input logic [1:0] s);
    @(negedge clock);
    {slot_limit_valid, slot_limit_value, slot_limit_scale} = {1'h1, v, s};
    @(negedge clock);
    // released lines never keep the last value
    {slot_limit_valid, slot_limit_value, slot_limit_scale} = {1'h0, ~v, ~s};
  endtask
  task automatic req(input logic [2:0] k);
    @(negedge clock);
    {req_valid, req_is_cfg, req_is_slot_limit} = k;
  endtask
endmodule
`default_nettype wire

// ===== aslpc_tb.sv
// self-checking bench for the global chip control bank
// assumes the partner model drives messages and requests
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb
  import aslpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 0, reset_n = 0, cfg_wr_en = 0, cfg_rd_en = 0;
  logic [7:0]  cfg_addr = 0, slot_limit_value;
  logic [3:0]  cfg_byte_en = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata, eeprom_load_data = 0, sh, w, m;
  logic        eeprom_load_valid = 0, slot_limit_valid, req_valid, req_is_cfg;
  logic        req_is_slot_limit, req_unsupported, link_low_power_l1_enable;
  logic [1:0]  slot_limit_scale, power_excess_action, act, s, ms;
  logic [0:0]  aspm_support_l1;
  logic [7:0]  v, mv;
  logic [2:0]  k;
  logic        exc, power_excess_out;
  int          err_count = 0, tests_run = 0, cycles = 0, seed;
  aslpc_global_ctrl i_aslpc_global_ctrl (.clock, .reset_n, .cfg_wr_en, .cfg_rd_en,
    .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_rdata, .eeprom_load_valid,
    .eeprom_load_data, .slot_limit_valid, .slot_limit_value, .slot_limit_scale,
    .req_valid, .req_is_cfg, .req_is_slot_limit, .req_unsupported,
    .link_low_power_l1_enable, .aspm_support_l1, .power_excess_action,
    .power_excess_out);
  aslpc_link_partner i_aslpc_link_partner (.clock, .slot_limit_valid,
    .slot_limit_value, .slot_limit_scale, .req_valid, .req_is_cfg, .req_is_slot_limit);
  always #25 clock = ~clock;
  function automatic int mw(input logic [7:0] x, input logic [1:0] c);
    return x * ((c == 0) ? 1000 : (c == 1) ? 100 : (c == 2) ? 10 : 1);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clock);
    {cfg_wr_en, cfg_addr, cfg_byte_en, cfg_wdata} = {1'h1, a, b, d};
    @(negedge clock);
    cfg_wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clock);
    {cfg_rd_en, cfg_addr} = {1'h1, a};
    @(negedge clock);
    cfg_rd_en = 0;
    `CHK("rdata", e, cfg_rdata)
  endtask
  task automatic wrap_up;
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      wrap_up;
    end
  end
  initial
  begin
    seed = 32'h739b76c5;
    sh = 0;
    repeat (2) @(negedge clock);
    reset_n = 1;
    rd(GCC_OFFSET, 0);
    repeat (10)
    begin
      w = $random(seed) & ~(32'h1 << DIAG_BIT);
      cfg_byte_en = 4'($random(seed));
      for (int i = 0; i < 4; i++)
        m[i*8+:8] = {8{cfg_byte_en[i]}};
      wr(GCC_OFFSET, cfg_byte_en, w);
      sh = ((sh & ~m) | (w & m)) & 32'h203ffc00;
      rd(GCC_OFFSET, sh);
      `CHK("l1", sh[29], link_low_power_l1_enable)
      `CHK("sup", sh[29], aspm_support_l1[0])
    end
    wr(8'hb4, 4'hf, 32'h2fffffff);
    rd(8'hb4, 0);
    rd(GCC_OFFSET, sh);
    $display("register test done");
    w = ($random(seed) | 32'h2000_0000) & ~(32'h1 << DIAG_BIT);
    @(negedge clock);
    {eeprom_load_valid, eeprom_load_data} = {1'h1, w};
    @(negedge clock);
    eeprom_load_valid = 0;
    rd(GCC_OFFSET, w & 32'h203ffc00);
    `CHK("l1", 1'h1, link_low_power_l1_enable)
    reset_n = 0;
    @(negedge clock);
    reset_n = 1;
    rd(GCC_OFFSET, 0);
    $display("load and reset test done");
    for (int i = 0; i < 48; i++)
    begin
      {act, ms} = i[3:0];
      mv = (i < 16) ? 8'h00 : 8'($random(seed));
      wr(GCC_OFFSET, 4'hf, {10'h000, ms, mv, act, 10'h000});
      `CHK("act", act, power_excess_action)
      {v, s} = (i % 5 == 0) ? {mv, ms} : 10'($random(seed));
      i_aslpc_link_partner.send(v, s);
      @(negedge clock);
      exc = (mv != 0) && (mw(v, s) < mw(mv, ms));
      `CHK("excess", (act == 1 || act == 2) && exc, power_excess_out)
      k = 3'($random(seed)) | 3'h4;
      i_aslpc_link_partner.req(k);
      #1 `CHK("unsup", act == 2 && exc && k == 3'h4, req_unsupported)
      repeat (3) @(negedge clock);
      `CHK("hold", (act == 1 || act == 2) && exc, power_excess_out)
      // release the request lines so no request class lingers into the next pass
      i_aslpc_link_partner.req(3'h0);
      #1 `CHK("idle", 1'h0, req_unsupported)
    end
    $display("power compare test done");
    wrap_up;
  end
endmodule
`default_nettype wire
